// >>> i2c_slave_register_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_access_tb_top;
   logic              core_clk;
   logic              reset_n;
   logic [2:0]        addr_strap;
   logic              cfg_wr_en;
   logic [11:0]       cfg_addr;
   logic [3:0]        cfg_wr_be;
   logic [31:0]       cfg_wr_data;
   logic [31:0]       cfg_rd_data;
   logic              slave_busy;
   logic              acc_req;
   i2s_pkg::i2s_acc_t acc;
   i2s_pkg::i2s_acc_t acc_seen;
   logic              acc_rd_valid;
   logic [31:0]       acc_rd_data;
   logic              scl_o, scl_oe_n, sda_o, sda_oe_n, scl_drv_n, sda_drv_n;
   logic              scl_line, sda_line;
   logic [9:0]        acks;
   int                fails, n_compared, n_req, req_total;
   localparam logic [63:0] WR = 64'h0308BC14_12345678;
   // pull-ups on both lines
   assign scl_line = scl_drv_n & (scl_oe_n | scl_o);
   assign sda_line = sda_drv_n & (sda_oe_n | sda_o);

   i2s_slave i2s_slave_i (
      .core_clk(core_clk), .reset_n(reset_n),
      .slave_port_clock_line_i(scl_line), .slave_port_clock_line_o(scl_o),
      .slave_port_clock_line_oe_n(scl_oe_n), .slave_port_data_line_i(sda_line),
      .slave_port_data_line_o(sda_o), .slave_port_data_line_oe_n(sda_oe_n),
      .addr_strap(addr_strap), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
      .cfg_wr_be(cfg_wr_be), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
      .slave_busy(slave_busy), .acc_req(acc_req), .acc(acc),
      .acc_rd_valid(acc_rd_valid), .acc_rd_data(acc_rd_data));
   i2s_master_model i2s_master_model_i (
      .core_clk(core_clk), .sda_line(sda_line), .scl_drv_n(scl_drv_n), .sda_drv_n(sda_drv_n));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (reset_n !== 1'b1) begin
         req_total <= 0;
      end else if (acc_req === 1'b1) begin
         req_total <= req_total + 1;
         acc_seen  <= acc;
      end
   end
   // ----------------
   // helpers
   // ----------------
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic results();
      if (fails == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   task automatic t_reset(input logic [2:0] s);
      reset_n    <= 1'b0;
      addr_strap <= s;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask : t_reset
   task automatic cfg_wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      cfg_wr_en   <= 1'b1;
      cfg_addr    <= a;
      cfg_wr_be   <= be;
      cfg_wr_data <= d;
      @(posedge core_clk);
      cfg_wr_en <= 1'b0;
      @(posedge core_clk);
   endtask : cfg_wr
   task automatic cfg_rd(input logic [11:0] a, input logic [31:0] exp);
      cfg_addr <= a;
      repeat (2) @(posedge core_clk);
      chk("cfg_rd_data", cfg_rd_data, exp);
   endtask : cfg_rd
   // whole packet in one frame: address, four command bytes, data bytes
   task automatic pkt(input logic [79:0] v, input int nb);
      int base;
      base = req_total;
      acks = '1;
      i2s_master_model_i.start();
      for (int i = 0; i < nb; i++) i2s_master_model_i.put(v[79-8*i -: 8], acks[i]);
      i2s_master_model_i.stop();
      n_req = req_total - base;
      chk("slave_busy", slave_busy, 1'b0);
   endtask : pkt
   // ----------------
   // scenarios
   // ----------------
   task automatic s_write();
      logic [71:0] v9;
      logic        k;
      int          base;
      pkt({8'h3E, WR, 8'h00}, 9);
      chk("acks", acks, 10'h200);
      chk("acc_req count", n_req, 1);
      chk("acc", acc_seen, {1'b1, 1'b0, 3'h4, 2'h1, 10'h014, 4'hF, 32'h12345678});
      pkt({8'h3E, WR, 8'h9A}, 10);
      chk("surplus acks", acks, 10'h200);
      chk("surplus acc_req", n_req, 0);
      // a repeated start closes a write as well as a stop does
      v9   = {8'h3E, WR};
      base = req_total;
      i2s_master_model_i.start();
      for (int i = 0; i < 9; i++) i2s_master_model_i.put(v9[71-8*i -: 8], k);
      i2s_master_model_i.start();
      i2s_master_model_i.stop();
      chk("restart acc_req", req_total - base, 1);
   endtask : s_write
   task automatic s_read();
      logic [7:0] b;
      logic       k;
      pkt({8'h3E, 32'h0408BC14, 40'h0}, 5);
      chk("rd acks", acks, 10'h3E0);
      chk("rd acc_req", n_req, 1);
      chk("rd acc", {acc_seen.write, acc_seen.be, acc_seen.dw_addr}, {1'b0, 4'hF, 10'h014});
      acc_rd_valid <= 1'b1;
      acc_rd_data  <= 32'hA1B2C3D4;
      @(posedge core_clk);
      acc_rd_valid <= 1'b0;
      acc_rd_data  <= 32'h5A5A5A5A;
      @(posedge core_clk);
      i2s_master_model_i.start();
      i2s_master_model_i.put(8'h3F, k);
      chk("rd addr ack", k, 1'b0);
      for (int i = 0; i < 6; i++) begin
         i2s_master_model_i.get(i == 5, b);
         chk("rd byte", b, 8'hA1 + 8'h11 * (i % 4));
      end
      i2s_master_model_i.stop();
   endtask : s_read
   // every command code, then every byte-enable pattern on writes
   task automatic s_codes();
      logic [2:0] code;
      logic [3:0] be;
      for (int i = 0; i < 24; i++) begin
         code = (i < 8) ? 3'(i) : 3'h3;
         be   = 4'(i);
         pkt({8'h3E, 5'h0, code, 8'h08, 2'b10, be, 2'b00, 8'h14, {4{8'(i)}}, 8'h00}, 9);
         chk("code acc_req", n_req, (code == 3'h3) ? 1 : 0);
         if (code == 3'h3) begin
            chk("be acc", acc_seen, {1'b1, 1'b0, 3'h4, 2'h1, 10'h014, be, {4{8'(i)}}});
         end
      end
   endtask : s_codes
   task automatic s_strap();
      t_reset(3'h5);
      cfg_rd(12'h294, 32'h1F);
      pkt({8'h3E, WR, 8'h00}, 9);
      chk("miss acks", acks, 10'h3FF);
      chk("miss acc_req", n_req, 0);
      pkt({8'h3A, WR, 8'h00}, 9);
      chk("strap acks", acks, 10'h200);
      cfg_wr(12'h294, 4'h1, 32'h50);
      cfg_wr(12'h298, 4'hF, 32'hFFFFFFFF);
      cfg_rd(12'h294, 32'h50);
      pkt({8'hAA, WR, 8'h00}, 9);
      chk("cfg addr acks", acks, 10'h200);
      cfg_wr(12'h294, 4'h2, 32'hFFFFFFFF);
      cfg_rd(12'h294, 32'hFF50);
   endtask : s_strap
   // ----------------
   // main and watchdog
   // ----------------
   initial begin
      reset_n      = 1'b0;
      addr_strap   = 3'h7;
      cfg_wr_en    = 1'b0;
      cfg_addr     = 12'h000;
      cfg_wr_be    = 4'h0;
      cfg_wr_data  = 32'h0;
      acc_rd_valid = 1'b0;
      acc_rd_data  = 32'h0;
      fails        = 0;
      n_compared   = 0;
      n_req        = 0;
      @(posedge core_clk);
      t_reset(3'h7);
      cfg_rd(12'h294, 32'h1F);
      cfg_rd(12'h298, 32'h0);
      s_write();
      s_read();
      s_codes();
      s_strap();
      results();
   end
   // about 70k cycles of traffic expected
   initial begin
      repeat (90000) @(posedge core_clk);
      fails++;
      results();
   end
endmodule : i2c_slave_register_access_tb_top
`default_nettype wire

// >>> i2s_map.svh
`ifndef I2S_MAP_SVH
`define I2S_MAP_SVH
// ---------------------------------------------
// register map
// ---------------------------------------------
`define I2S_SLV_CFG_OFS   12'h294
`define I2S_SLV_CFG_RST   32'h0000001F
`define I2S_CFG_ADDR_HI   6:3
// ---------------------------------------------
// command codes, field positions and strap default
// ---------------------------------------------
`define I2S_CMD_WR        3'h3
`define I2S_CMD_RD        3'h4
`define I2S_CMD_CODE      2:0
`define I2S_STRAP_DFLT    3'h7
// ---------------------------------------------
// byte phase, bit and strap wait counts
// ---------------------------------------------
`define I2S_PH_ADDR       4'h0
`define I2S_PH_CMD_LAST   4'h4
`define I2S_PH_DAT_LAST   4'h8
`define I2S_PH_WR_DONE    4'h9
`define I2S_PH_RD_DONE    4'h5
`define I2S_BIT_LAST_RX   4'h8
`define I2S_BIT_LAST_TX   4'h7
`define I2S_STRAP_WAIT    2'h3
`endif

// >>> i2s_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// two-wire bus master
// ----------------
// open drain: a low drive pulls the line, a high drive releases it
module i2s_master_model (
   input  wire logic core_clk,
   input  wire logic sda_line,
   output logic      scl_drv_n,
   output logic      sda_drv_n
);
   initial begin
      scl_drv_n = 1'b1;
      sda_drv_n = 1'b1;
   end
   // 9 cycles per phase keeps each clock level over the 8-cycle minimum
   task automatic drv(input logic c, input logic d);
      scl_drv_n <= c;
      sda_drv_n <= d;
      repeat (9) @(posedge core_clk);
   endtask : drv
   // data moves only while the clock is low, so no false start or stop
   task automatic bit_io(input logic b, output logic seen);
      drv(1'b0, sda_drv_n);
      drv(1'b0, b);
      drv(1'b1, b);
      seen = sda_line;
   endtask : bit_io
   task automatic start();
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      drv(1'b1, 1'b0);
   endtask : start
   task automatic stop();
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b1);
   endtask : stop
   task automatic put(input logic [7:0] v, output logic ack_n);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, ack_n);
   endtask : put
   task automatic get(input logic last, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(last, s);
   endtask : get
endmodule : i2s_master_model
`default_nettype wire

// >>> i2s_pkg.sv
package i2s_pkg;
   typedef enum logic [2:0] {
      S_IDLE,
      S_RX,
      S_ACK,
      S_TX,
      S_TXACK,
      S_IGN
   } i2s_state_t;

   typedef struct packed {
      logic        write;
      logic        nt_link;
      logic [2:0]  station;
      logic [1:0]  port;
      logic [9:0]  dw_addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } i2s_acc_t;
endpackage : i2s_pkg

// >>> i2s_slave.sv
`include "i2s_map.svh"
`timescale 1ns/1ps
`default_nettype none

module i2s_slave (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // two-wire pins and address strap
   input  wire logic             slave_port_clock_line_i,
   output logic                  slave_port_clock_line_o,
   output logic                  slave_port_clock_line_oe_n,
   input  wire logic             slave_port_data_line_i,
   output logic                  slave_port_data_line_o,
   output logic                  slave_port_data_line_oe_n,
   input  wire logic [2:0]       addr_strap,
   // local register write and read, busy flag
   input  wire logic             cfg_wr_en,
   input  wire logic [11:0]      cfg_addr,
   input  wire logic [3:0]       cfg_wr_be,
   input  wire logic [31:0]      cfg_wr_data,
   output logic [31:0]           cfg_rd_data,
   output logic                  slave_busy,
   // register space access
   output logic                  acc_req,
   output i2s_pkg::i2s_acc_t     acc,
   input  wire logic             acc_rd_valid,
   input  wire logic [31:0]      acc_rd_data
);

   // ---------------------------------------------
   // synchronisers and edge detect
   // ---------------------------------------------
   logic       scl_s1, scl_s2, scl_d;
   logic       sda_s1, sda_s2, sda_d;
   logic [2:0] strap_s1, strap_s2;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         scl_s1   <= 1'b1;
         scl_s2   <= 1'b1;
         scl_d    <= 1'b1;
         sda_s1   <= 1'b1;
         sda_s2   <= 1'b1;
         sda_d    <= 1'b1;
         strap_s1 <= `I2S_STRAP_DFLT;
         strap_s2 <= `I2S_STRAP_DFLT;
      end else begin
         scl_s1   <= slave_port_clock_line_i;
         scl_s2   <= scl_s1;
         scl_d    <= scl_s2;
         sda_s1   <= slave_port_data_line_i;
         sda_s2   <= sda_s1;
         sda_d    <= sda_s2;
         strap_s1 <= addr_strap;
         strap_s2 <= strap_s1;
      end
   end

   logic start_det, stop_det, scl_rise, scl_fall;
   assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
   assign stop_det  = scl_s2 && scl_d && !sda_d && sda_s2;
   assign scl_rise  = scl_s2 && !scl_d;
   assign scl_fall  = !scl_s2 && scl_d;

   // ---------------------------------------------
   // strap capture and slave address
   // ---------------------------------------------
   // straps are caught once, after the synchroniser has settled
   logic [1:0]  strap_wait;
   logic [2:0]  strap_reg;
   logic [31:0] slv_cfg_reg;
   logic [6:0]  slave_addr;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         strap_wait <= 2'h0;
         strap_reg  <= `I2S_STRAP_DFLT;
      end else if (strap_wait != `I2S_STRAP_WAIT) begin
         strap_wait <= strap_wait + 2'h1;
         strap_reg  <= strap_s2;
      end
   end

   assign slave_addr = {slv_cfg_reg[`I2S_CFG_ADDR_HI], strap_reg};

   // ---------------------------------------------
   // slave configuration register
   // ---------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         slv_cfg_reg <= `I2S_SLV_CFG_RST;
      end else if (cfg_wr_en && cfg_addr == `I2S_SLV_CFG_OFS) begin
         for (int i = 0; i < 4; i++) begin
            if (cfg_wr_be[i]) begin
               slv_cfg_reg[8*i +: 8] <= cfg_wr_data[8*i +: 8];
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cfg_rd_data <= 32'h0;
      end else begin
         cfg_rd_data <= (cfg_addr == `I2S_SLV_CFG_OFS) ? slv_cfg_reg : 32'h0;
      end
   end

   // ---------------------------------------------
   // byte engine
   // ---------------------------------------------
   i2s_pkg::i2s_state_t st;
   logic [3:0]  ph;
   logic [3:0]  bit_cnt;
   logic [7:0]  rx_byte;
   logic [7:0]  tx_byte;
   logic        ack_flag;
   logic        rw_reg;
   logic [1:0]  rd_idx;
   logic [31:0] rd_buf;
   logic [7:0]  cmd_q [0:3];
   logic [31:0] wd_q;
   logic        byte_done;

   assign byte_done = (st == i2s_pkg::S_RX) && scl_fall && bit_cnt == `I2S_BIT_LAST_RX;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st       <= i2s_pkg::S_IDLE;
         ph       <= 4'h0;
         bit_cnt  <= 4'h0;
         rx_byte  <= 8'h00;
         tx_byte  <= 8'h00;
         ack_flag <= 1'b0;
         rw_reg   <= 1'b0;
         rd_idx   <= 2'h0;
      end else if (start_det) begin
         st      <= i2s_pkg::S_RX;
         ph      <= `I2S_PH_ADDR;
         bit_cnt <= 4'h0;
         rd_idx  <= 2'h0;
      end else if (stop_det) begin
         st <= i2s_pkg::S_IDLE;
      end else begin
         case (st)
            i2s_pkg::S_RX: begin
               if (scl_rise && bit_cnt != `I2S_BIT_LAST_RX) begin
                  rx_byte <= {rx_byte[6:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  bit_cnt <= 4'h0;
                  st      <= i2s_pkg::S_ACK;
                  if (ph != 4'hF) begin
                     ph <= ph + 4'h1;
                  end
                  if (ph == `I2S_PH_ADDR) begin
                     rw_reg   <= rx_byte[0];
                     ack_flag <= rx_byte[7:1] == slave_addr;
                  end else begin
                     ack_flag <= ph <= `I2S_PH_DAT_LAST;
                  end
               end
            end
            i2s_pkg::S_ACK: begin
               if (scl_fall) begin
                  if (!ack_flag && ph == 4'h1) begin
                     st <= i2s_pkg::S_IGN;
                  end else if (rw_reg) begin
                     st      <= i2s_pkg::S_TX;
                     tx_byte <= rd_buf[8*(3-rd_idx) +: 8];
                     rd_idx  <= rd_idx + 2'h1;
                  end else begin
                     st <= i2s_pkg::S_RX;
                  end
               end
            end
            i2s_pkg::S_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == `I2S_BIT_LAST_TX) begin
                     st      <= i2s_pkg::S_TXACK;
                     bit_cnt <= 4'h0;
                  end else begin
                     tx_byte <= {tx_byte[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            i2s_pkg::S_TXACK: begin
               if (scl_rise && sda_s2) begin
                  st <= i2s_pkg::S_IGN;
               end else if (scl_fall) begin
                  // wraps after four bytes, so long reads repeat the word
                  st      <= i2s_pkg::S_TX;
                  tx_byte <= rd_buf[8*(3-rd_idx) +: 8];
                  rd_idx  <= rd_idx + 2'h1;
               end
            end
            i2s_pkg::S_IDLE, i2s_pkg::S_IGN: begin
               st <= st;
            end
            default: begin
               st <= i2s_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // command and data capture
   // ---------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            cmd_q[i] <= 8'h00;
         end
         wd_q <= 32'h0;
      end else if (byte_done && ph != `I2S_PH_ADDR) begin
         if (ph <= `I2S_PH_CMD_LAST) begin
            cmd_q[ph[1:0] - 2'h1] <= rx_byte;
         end else if (ph <= `I2S_PH_DAT_LAST) begin
            wd_q[8*(`I2S_PH_DAT_LAST - ph) +: 8] <= rx_byte;
         end
      end
   end

   // ---------------------------------------------
   // register space access
   // ---------------------------------------------
   logic       end_evt;
   logic [2:0] cmd_code;
   assign end_evt  = (start_det || stop_det) && !rw_reg
                   && st != i2s_pkg::S_IDLE && st != i2s_pkg::S_IGN;
   assign cmd_code = cmd_q[0][`I2S_CMD_CODE];

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         acc_req <= 1'b0;
         acc     <= '0;
      end else begin
         acc_req <= 1'b0;
         // anything but a full write or a bare read command is dropped
         if (end_evt && ((cmd_code == `I2S_CMD_WR && ph == `I2S_PH_WR_DONE)
                      || (cmd_code == `I2S_CMD_RD && ph == `I2S_PH_RD_DONE))) begin
            acc_req       <= 1'b1;
            acc.write     <= cmd_code == `I2S_CMD_WR;
            acc.nt_link   <= cmd_q[1][4];
            acc.station   <= cmd_q[1][3:1];
            acc.port      <= {cmd_q[1][0], cmd_q[2][7]};
            acc.be        <= cmd_q[2][5:2];
            acc.dw_addr   <= {cmd_q[2][1:0], cmd_q[3]};
            acc.wdata     <= wd_q;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rd_buf <= 32'h0;
      end else if (acc_rd_valid) begin
         rd_buf <= acc_rd_data;
      end
   end

   // ---------------------------------------------
   // pin drivers
   // ---------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         slave_port_data_line_oe_n  <= 1'b1;
         slave_port_data_line_o     <= 1'b0;
         slave_port_clock_line_oe_n <= 1'b1;
         slave_port_clock_line_o    <= 1'b0;
         slave_busy                 <= 1'b0;
      end else begin
         slave_port_data_line_oe_n  <= !((st == i2s_pkg::S_ACK && ack_flag)
                                       || (st == i2s_pkg::S_TX && !tx_byte[7]));
         slave_port_data_line_o     <= 1'b0;
         // no clock stretching: the clock line is never pulled
         slave_port_clock_line_oe_n <= 1'b1;
         slave_port_clock_line_o    <= 1'b0;
         slave_busy                 <= st != i2s_pkg::S_IDLE;
      end
   end

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_ack_begin;
      $rose(st == i2s_pkg::S_ACK) && ack_flag;
   endsequence

   a_ack_drive:
   assert property (s_ack_begin ##1 (st == i2s_pkg::S_ACK) |-> !slave_port_data_line_oe_n)
      else $error("ack not driven");

   a_addr_mismatch:
   assert property ((st == i2s_pkg::S_ACK && ph == 4'h1 && rx_byte[7:1] != slave_addr)
                    |=> slave_port_data_line_oe_n)
      else $error("mismatched address acknowledged");

   a_surplus_nak:
   assert property ((st == i2s_pkg::S_ACK && ph > `I2S_PH_WR_DONE) |=> slave_port_data_line_oe_n)
      else $error("surplus byte acknowledged");

   a_addr_compose:
   assert property ((st == i2s_pkg::S_ACK && ph == 4'h1 && ack_flag)
                    |-> rx_byte[3:1] == strap_reg && rx_byte[7:4] == slv_cfg_reg[6:3])
      else $error("address acknowledged against wrong bits");

   a_cfg_reset:
   assert property ($past(!reset_n) |-> slv_cfg_reg == `I2S_SLV_CFG_RST)
      else $error("config reset value wrong");

   a_wr_code:
   assert property ((acc_req && acc.write) |-> $past(cmd_code) == `I2S_CMD_WR && $past(ph) == 4'h9)
      else $error("write issued without write code");

   a_rd_code:
   assert property ((acc_req && !acc.write) |-> $past(cmd_code) == `I2S_CMD_RD && $past(ph) == 4'h5)
      else $error("read issued without read code");

   a_rd_buffer:
   assert property (acc_rd_valid |=> rd_buf == $past(acc_rd_data))
      else $error("read buffer not loaded");

   a_rd_first_byte:
   assert property ((st == i2s_pkg::S_ACK && rw_reg && ack_flag && scl_fall && !start_det && !stop_det)
                    |=> tx_byte == rd_buf[31:24])
      else $error("read did not start at top byte");

   a_wr_order:
   assert property ((byte_done && ph == 4'h5)
                    |=> wd_q[31:24] == $past(rx_byte))
      else $error("write byte order wrong");

endmodule : i2s_slave

`default_nettype wire
